// ===== rtl/io_port_regs.svh
`ifndef IO_PORT_REGS_SVH
`define IO_PORT_REGS_SVH
// Offsets from the base of the port-control space.
`define OFS_PIN_LEVEL 5'h02
`define OFS_PIN_LEVEL_B 5'h03
`define OFS_DIRECTION 5'h04
`define OFS_DIRECTION_B 5'h05
`define OFS_OUTPUT_DATA 5'h06
`define OFS_OUTPUT_DATA_B 5'h07
`define OFS_POWER_SAVING 5'h10
`define OFS_PAGE_SELECT 5'h18
// Size of the space in bytes.
`define IO_SPACE_BYTES 5'h18
// Reset values.
`define RST_DIRECTION 8'h00
`define RST_OUTPUT_DATA 8'h00
`define RST_POWER_SAVING 8'h00
`define RST_PAGE_SELECT 8'h00
`endif

// ===== rtl/io_port_pkg.sv
`default_nettype none
package io_port_pkg;
  // One host bus access as seen by the decoder.
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic rd;
    logic wr;
    logic upper_byte_enable_n;
  } host_access_t;
  // Whole state of the register map.
  typedef struct packed {
    logic [7:0] dir_a;
    logic [7:0] dir_b;
    logic [7:0] dat_a;
    logic [7:0] dat_b;
    logic [7:0] power_saving;
    logic [7:0] page_select;
    logic [7:0] pin_a_s1;
    logic [7:0] pin_a_s2;
    logic [7:0] pin_a_s3;
    logic [7:0] pin_b_s1;
    logic [7:0] pin_b_s2;
    logic [7:0] pin_b_s3;
    logic [7:0] pin_a;
    logic [7:0] pin_b;
    logic [15:0] rdata;
    logic hit;
  } map_state_t;
endpackage
`default_nettype wire

// ===== rtl/io_port_register_map.sv
`timescale 1ns/10ps
`default_nettype none
`include "io_port_regs.svh"

// Notes on behaviour
// - 24-byte control space at programmable base.
// - Space selected by address bits 15 to 8.
// - Extra low address lines may refine decode.
// - Word bus still allows single byte access.
// - Byte layout A: pin 2, dir 4, data 6.
// - Byte layout B: pin 3, dir 5, data 7.
// - Word layout: pin 2, dir 4, data 6.
// - Power-saving register at offset 10.
// - Page register at offset 18.
// - Direction and data reset zero; one drives.
// - Pin read returns sampled pin level.
module io_port_register_map (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset_n,
  // Host access and configuration.
  input wire io_port_pkg::host_access_t host,
  input wire logic bus_is_16bit,
  input wire logic [7:0] base_high,
  input wire logic [2:0] aux_match_enable,
  input wire logic [2:0] aux_match_value,
  input wire logic [2:0] aux_lines,
  // Read answer.
  output logic [15:0] read_data,
  output logic io_space_select,
  // Port pins.
  input wire logic [7:0] port_a_in,
  input wire logic [7:0] port_b_in,
  output logic [7:0] port_a_out,
  output logic [7:0] port_a_oe,
  output logic [7:0] port_b_out,
  output logic [7:0] port_b_oe,
  // Power-saving and page values for other blocks.
  output logic [7:0] power_saving_control,
  output logic [7:0] memory_page_select
);
  // Types of the map come from the package.
  import io_port_pkg::*;

  // Registered state and its next value.
  map_state_t state_reg;
  map_state_t state_next;
  // Decode results for this cycle.
  logic sel; // Upper lines match the base and enabled auxiliary lines match their value.
  logic [4:0] ofs; // Byte offset inside the space.
  logic in_map; // The access falls on a location of the space.
  logic do_wr; // Write that lands inside the space.
  logic do_rd; // Read that lands inside the space.
  logic byte_hi; // Word bus access that also carries the upper lane.

  // Space select: upper lines match base, masked aux lines match value.
  function automatic logic space_hit(input logic [15:0] a, input logic [7:0] b,
                                     input logic [2:0] en, input logic [2:0] v,
                                     input logic [2:0] aux);
    space_hit = (a[15:8] == b) && (((aux ^ v) & en) == 3'h0);
  endfunction

  // Offsets of the 24-byte run, plus the page register that sits just past it.
  // Without the second term the page register could never be reached.
  function automatic logic in_space(input logic [4:0] o);
    in_space = (o < `IO_SPACE_BYTES) || (o == `OFS_PAGE_SELECT);
  endfunction

  // Byte for a Port B register: upper lane on a word bus, lower lane otherwise.
  function automatic logic [7:0] lane_b(input logic [15:0] wd, input logic is16);
    lane_b = is16 ? wd[15:8] : wd[7:0];
  endfunction

  // Settled pin byte: a bit moves only where stages two and three agree,
  // so a level caught mid-change by the first stage is never reported.
  function automatic logic [7:0] settle(input logic [7:0] cur, input logic [7:0] s2,
                                        input logic [7:0] s3);
    settle = (s3 & ~(s2 ^ s3)) | (cur & (s2 ^ s3));
  endfunction

  // Decode and next-state computation.
  always_comb begin
    // Hold the control registers unless the decoded access below changes them; pin stages, select and answer reload each cycle.
    state_next = state_reg;
    // Decode of the host address for this cycle.
    sel = space_hit(host.addr, base_high, aux_match_enable, aux_match_value, aux_lines);
    ofs = host.addr[4:0];
    in_map = sel && in_space(ofs);
    do_wr = in_map && host.wr;
    do_rd = in_map && host.rd;
    // Word bus access of the odd lane is wanted when upper enable is low.
    byte_hi = bus_is_16bit && !host.upper_byte_enable_n;
    // Pin sampling: three stages, accept a change once stages two and three agree.
    // Port A stages.
    state_next.pin_a_s1 = port_a_in;
    state_next.pin_a_s2 = state_reg.pin_a_s1;
    state_next.pin_a_s3 = state_reg.pin_a_s2;
    // Port B stages.
    state_next.pin_b_s1 = port_b_in;
    state_next.pin_b_s2 = state_reg.pin_b_s1;
    state_next.pin_b_s3 = state_reg.pin_b_s2;
    // Settled bytes that the pin-level registers return.
    state_next.pin_a = settle(state_reg.pin_a, state_reg.pin_a_s2, state_reg.pin_a_s3);
    state_next.pin_b = settle(state_reg.pin_b, state_reg.pin_b_s2, state_reg.pin_b_s3);
    // Select answers any read or write inside the space, mapped or not.
    state_next.hit = do_rd || do_wr;
    // Writes: read-only and unassigned offsets fall through untouched.
    if (do_wr) begin
      case (ofs)
        // Direction, Port A lane; Port B too on a word bus with upper enable low.
        `OFS_DIRECTION: begin
          if (byte_hi) begin
            state_next.dir_b = host.wdata[15:8];
          end
          state_next.dir_a = host.wdata[7:0];
        end
        // Direction, Port B alone, from the lane that carries it.
        `OFS_DIRECTION_B: begin
          state_next.dir_b = lane_b(host.wdata, bus_is_16bit);
        end
        // Output data, Port A lane; Port B too on a word bus with upper enable low.
        `OFS_OUTPUT_DATA: begin
          if (byte_hi) begin
            state_next.dat_b = host.wdata[15:8];
          end
          state_next.dat_a = host.wdata[7:0];
        end
        // Output data, Port B alone.
        `OFS_OUTPUT_DATA_B: begin
          state_next.dat_b = lane_b(host.wdata, bus_is_16bit);
        end
        // Power-saving control byte.
        `OFS_POWER_SAVING: begin
          state_next.power_saving = host.wdata[7:0];
        end
        // Page select byte.
        `OFS_PAGE_SELECT: begin
          state_next.page_select = host.wdata[7:0];
        end
        // Pin levels and unassigned offsets leave every register as it is.
        default: begin
          state_next.hit = state_next.hit;
        end
      endcase
    end
    // Reads: answer is registered; unassigned offsets read as zero.
    state_next.rdata = 16'h0000;
    if (do_rd) begin
      case (ofs)
        // Pin levels of both ports, Port A in the low lane.
        `OFS_PIN_LEVEL: begin
          state_next.rdata = {state_reg.pin_b, state_reg.pin_a};
        end
        // Port B pin level, placed on both lanes.
        `OFS_PIN_LEVEL_B: begin
          state_next.rdata = {state_reg.pin_b, state_reg.pin_b};
        end
        // Direction of both ports.
        `OFS_DIRECTION: begin
          state_next.rdata = {state_reg.dir_b, state_reg.dir_a};
        end
        // Direction of Port B on both lanes.
        `OFS_DIRECTION_B: begin
          state_next.rdata = {state_reg.dir_b, state_reg.dir_b};
        end
        // Output data of both ports.
        `OFS_OUTPUT_DATA: begin
          state_next.rdata = {state_reg.dat_b, state_reg.dat_a};
        end
        // Output data of Port B on both lanes.
        `OFS_OUTPUT_DATA_B: begin
          state_next.rdata = {state_reg.dat_b, state_reg.dat_b};
        end
        // Power-saving byte in the low lane.
        `OFS_POWER_SAVING: begin
          state_next.rdata = {8'h00, state_reg.power_saving};
        end
        // Page byte in the low lane.
        `OFS_PAGE_SELECT: begin
          state_next.rdata = {8'h00, state_reg.page_select};
        end
        // Unassigned offsets answer zero.
        default: begin
          state_next.rdata = 16'h0000;
        end
      endcase
    end
  end

  // State register; control bits reset so every pin starts as input.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      // Clear all stages and the answer, then load the control reset values.
      state_reg <= '0;
      state_reg.dir_a <= `RST_DIRECTION;
      state_reg.dir_b <= `RST_DIRECTION;
      state_reg.dat_a <= `RST_OUTPUT_DATA;
      state_reg.dat_b <= `RST_OUTPUT_DATA;
      // Power-saving and page bytes start at their reset values.
      state_reg.power_saving <= `RST_POWER_SAVING;
      state_reg.page_select <= `RST_PAGE_SELECT;
    end else begin
      // Every register runs on every edge.
      state_reg <= state_next;
    end
  end

  // Outputs come straight from the state flip-flops.
  // Host-facing answer.
  assign read_data = state_reg.rdata;
  assign io_space_select = state_reg.hit;
  // Pad drive: a direction bit of one enables the pad.
  assign port_a_out = state_reg.dat_a;
  assign port_a_oe = state_reg.dir_a;
  assign port_b_out = state_reg.dat_b;
  assign port_b_oe = state_reg.dir_b;
  // Values handed to other blocks.
  assign power_saving_control = state_reg.power_saving;
  assign memory_page_select = state_reg.page_select;
endmodule // io_port_register_map
`default_nettype wire

// ===== bench/io_port_register_map_assertions.sv
`timescale 1ns/10ps
`default_nettype none
// Ties decode and register effects to the access that caused them.
module io_port_chk (
  // Clock, reset and host side.
  input wire logic clock,
  input wire logic reset_n,
  input wire io_port_pkg::host_access_t host,
  input wire logic bus_is_16bit,
  input wire logic [7:0] base_high,
  // Map outputs.
  input wire logic io_space_select,
  input wire logic [7:0] port_a_oe,
  input wire logic [7:0] port_b_oe,
  input wire logic [7:0] port_a_out,
  input wire logic [7:0] power_saving_control
);
  import io_port_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  wire logic w = host.wr;
  wire logic [4:0] o = host.addr[4:0];
  wire logic [7:0] d = host.wdata[7:0];
  a_idle_quiet: assert property (!(host.rd || w) |=> !io_space_select)
    else $error("select without access");
  a_base_miss: assert property (host.addr[15:8] != base_high |=> !io_space_select)
    else $error("select off base");
  a_dir_a: assert property (w && o == 5'h04 |=> !io_space_select || port_a_oe == $past(d))
    else $error("direction a");
  a_dir_b: assert property (w && !bus_is_16bit && o == 5'h05
    |=> !io_space_select || port_b_oe == $past(d)) else $error("direction b");
  a_data_a: assert property (w && o == 5'h06 |=> !io_space_select || port_a_out == $past(d))
    else $error("data a");
  a_pin_ro: assert property (w && o == 5'h02 |=> $stable(port_a_oe) && $stable(port_a_out))
    else $error("pin write");
  a_word_gate: assert property (w && bus_is_16bit && host.upper_byte_enable_n && o == 5'h04
    |=> $stable(port_b_oe)) else $error("upper gate");
  a_power_wr: assert property (w && o == 5'h10
    |=> !io_space_select || power_saving_control == $past(d)) else $error("power");
endmodule // io_port_chk
bind io_port_register_map io_port_chk i_io_port_chk (.clock(clock), .reset_n(reset_n),
  .host(host), .bus_is_16bit(bus_is_16bit), .base_high(base_high), .port_a_oe(port_a_oe),
  .io_space_select(io_space_select), .port_b_oe(port_b_oe), .port_a_out(port_a_out),
  .power_saving_control(power_saving_control));
`default_nettype wire

// ===== bench/host_bus_model.sv
`timescale 1ns/10ps
`default_nettype none
// Host processor: one strobe cycle per call, then a released bus.
module host_bus_model (
  // Clock.
  input wire logic clock,
  // Bus out.
  output var io_port_pkg::host_access_t host,
  output logic [2:0] aux_lines,
  // Answer in.
  input wire logic [15:0] read_data,
  input wire logic io_space_select
);
  import io_port_pkg::*;
  initial host = '0;
  assign aux_lines = host.addr[7:5];
  // Released lines show inverted values so stale data never looks valid.
  task automatic xfer(input logic [15:0] a, input logic [15:0] wd, input logic r,
    input logic ube_n, output logic [15:0] rd, output logic sel);
    @(posedge clock);
    host <= '{a, wd, r, !r, ube_n};
    @(posedge clock);
    host <= '{~a, ~wd, 1'b0, 1'b0, 1'b1};
    #1;
    rd = read_data;
    sel = io_space_select;
  endtask
endmodule // host_bus_model
`default_nettype wire

// ===== bench/io_port_register_map_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
// Drives the map through the host model and judges each answer.
module io_port_register_map_tb_top;
  import io_port_pkg::*;
  localparam logic [7:0] BASE = 8'hA4;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic bus_is_16bit = 1'b0;
  logic [7:0] ext_b = 8'h00;
  logic [2:0] aux_en = 3'h7;
  host_access_t host;
  logic [2:0] aux;
  logic [15:0] rdata, rv;
  logic sel, sv;
  logic [7:0] a_in, b_in, a_out, a_oe, b_out, b_oe, psc, mps;
  int failures = 0;
  int n_tests = 0;
  // Driven pins follow the map; undriven Port A pins read high, undriven Port B pins follow ext_b.
  assign a_in = (a_oe & a_out) | ~a_oe;
  assign b_in = (b_oe & b_out) | (~b_oe & ext_b);
  initial begin
    forever #2.5 clock = ~clock;
  end
  io_port_register_map i_io_port_register_map (.clock(clock), .reset_n(reset_n), .host(host),
    .bus_is_16bit(bus_is_16bit), .base_high(BASE), .aux_match_enable(aux_en),
    .aux_match_value(3'h0), .aux_lines(aux), .read_data(rdata), .io_space_select(sel),
    .port_a_in(a_in), .port_b_in(b_in), .port_a_out(a_out), .port_a_oe(a_oe),
    .port_b_out(b_out), .port_b_oe(b_oe), .power_saving_control(psc), .memory_page_select(mps));
  host_bus_model i_host_bus_model (.clock(clock), .host(host), .aux_lines(aux),
    .read_data(rdata), .io_space_select(sel));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One access at an offset from the base.
  task automatic acc(input logic [4:0] o, input logic [15:0] wd, input logic r, input logic u);
    i_host_bus_model.xfer({BASE, 3'h0, o}, wd, r, u, rv, sv);
  endtask
  task automatic s_reset;
    acc(5'h04, 16'h0, 1'b1, 1'b1);
    chk(rv, 16'h0000);
    chk({a_oe, b_oe}, 16'h0000);
    acc(5'h06, 16'h0, 1'b1, 1'b1);
    chk(rv, 16'h0000);
    chk({a_out, b_out}, 16'h0000);
  endtask
  task automatic s_byte;
    acc(5'h04, 16'h005A, 1'b0, 1'b1);
    acc(5'h05, 16'h00C3, 1'b0, 1'b1);
    acc(5'h06, 16'h0033, 1'b0, 1'b1);
    acc(5'h07, 16'h00F0, 1'b0, 1'b1);
    acc(5'h02, 16'h00FF, 1'b0, 1'b1);
    chk({a_oe, b_oe}, 16'h5AC3);
    chk({a_out, b_out}, 16'h33F0);
    @(posedge clock);
    ext_b <= 8'h96;
    repeat (5) @(posedge clock);
    acc(5'h03, 16'h0, 1'b1, 1'b1);
    chk({8'h00, rv[7:0]}, 16'h00D4);
    acc(5'h02, 16'h0, 1'b1, 1'b1);
    chk(rv, 16'hD4B7);
  endtask
  task automatic s_word;
    @(posedge clock);
    bus_is_16bit <= 1'b1;
    acc(5'h04, 16'h1234, 1'b0, 1'b1);
    chk({a_oe, b_oe}, 16'h34C3);
    acc(5'h04, 16'h1234, 1'b0, 1'b0);
    acc(5'h04, 16'h0, 1'b1, 1'b0);
    chk(rv, 16'h1234);
    acc(5'h07, 16'hA500, 1'b0, 1'b0);
    chk({a_out, b_out}, 16'h33A5);
    acc(5'h06, 16'h5566, 1'b0, 1'b0);
    acc(5'h06, 16'h0, 1'b1, 1'b0);
    chk(rv, 16'h5566);
    @(posedge clock);
    bus_is_16bit <= 1'b0;
  endtask
  task automatic s_misc;
    acc(5'h10, 16'h005C, 1'b0, 1'b1);
    acc(5'h18, 16'h0007, 1'b0, 1'b1);
    chk({psc, mps}, 16'h5C07);
    acc(5'h18, 16'h0, 1'b1, 1'b1);
    chk({8'h00, rv[7:0]}, 16'h0007);
    acc(5'h14, 16'h0, 1'b1, 1'b1);
    chk(rv, 16'h0000);
    chk({15'h0, sv}, 16'h0001);
    acc(5'h1C, 16'h0, 1'b1, 1'b1);
    chk({15'h0, sv}, 16'h0000);
    i_host_bus_model.xfer(16'h0004, 16'h00FF, 1'b0, 1'b1, rv, sv);
    chk({a_oe, 7'h0, sv}, 16'h3400);
    i_host_bus_model.xfer({BASE, 8'h24}, 16'h00FF, 1'b0, 1'b1, rv, sv);
    chk({a_oe, 7'h0, sv}, 16'h3400);
    @(posedge clock);
    aux_en <= 3'h0;
    i_host_bus_model.xfer({BASE, 8'hE4}, 16'h0081, 1'b0, 1'b1, rv, sv);
    chk({a_oe, 7'h0, sv}, 16'h8101);
    @(posedge clock);
    aux_en <= 3'h7;
  endtask
  task automatic complete_run;
    $display("tests=%0d failures=%0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    s_reset;
    s_byte;
    s_word;
    s_misc;
    complete_run;
  end
  // A run that overstays its budget counts as a mismatch.
  initial begin
    #100000;
    failures++;
    complete_run;
  end
endmodule // io_port_register_map_tb_top
`default_nettype wire
